// ### hdl/cct_defs.svh
`ifndef CCT_DEFS_SVH
`define CCT_DEFS_SVH

// ==========================================================
// Register byte offsets
`define CCT_ADDR_REQ 8'h00
`define CCT_ADDR_CMD 8'h04
`define CCT_ADDR_PEND 8'h08
`define CCT_ADDR_STATUS 8'h0C
`define CCT_ADDR_LIMIT 8'h10

// ==========================================================
// Register fields
`define CCT_CMD_LEN 12:0
`define CCT_CMD_TAG 20:16
`define CCT_CMD_NODATA 24
`define CCT_CMD_FUNC 25
`define CCT_PEND_HDR 7:0
`define CCT_PEND_DATA 26:16
`define CCT_ST_PEND 0
`define CCT_ST_OVERSIZE 1
`define CCT_ST_LOST 2
`define CCT_ST_STALL 3
`define CCT_ST_MRRS 10:8
`define CCT_LIM_LIMIT 7:0
`define CCT_LIM_COUNT 23:16

// ==========================================================
// Endpoint fields, reserved space and defaults
`define CCT_DEV_CTRL_MRRS 14:12
`define CCT_TOTAL_HDR 64
`define CCT_TOTAL_DATA_BYTES 15872
`define CCT_CREDIT_SHIFT 4'h4
`define CCT_MRRS_BASE_SHIFT 4'h7
`define CCT_MRRS_MAX_CODE 3'h5
`define CCT_DEFAULT_MRRS 3'h0
`define CCT_RCB_BASE_SHIFT 4'h6
`define CCT_DEFAULT_RCB 1'h0
`define CCT_ADDR_LOW 11:0

`endif

// ### hdl/cct_pkg.sv
package cct_pkg;

	// ==========================================================
	// Accounting options and controller states
	typedef enum {
		CCT_REQUEST_COUNT_OPTION,
		CCT_PER_PACKET_CREDIT_OPTION,
		CCT_PER_BOUNDARY_CREDIT_OPTION,
		CCT_FINE_DATA_CREDIT_OPTION
	} cct_option_t;

	typedef enum {
		CCT_IDLE,
		CCT_HOLD
	} cct_state_t;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [31:0] addr;
		logic [12:0] len;
		logic [4:0] tag;
		logic func;
		logic no_data;
	} cct_req_t;

	typedef struct packed {
		logic [6:0] lower_addr;
		logic [12:0] len;
		logic [4:0] tag;
		logic func;
		logic last;
	} cct_cpl_t;

	typedef struct packed {
		logic [7:0] hdr;
		logic [10:0] data;
	} cct_charge_t;

endpackage

// ### hdl/cct_charge_mem.sv
`timescale 1ns/1ps

module cct_charge_mem (
	// Clock
	input wire logic sys_clk,
	// Write port
	input wire logic wr_en,
	input wire logic [4:0] wr_addr,
	input wire cct_pkg::cct_charge_t wr_data,
	// Read port, data one cycle after the strobe
	input wire logic rd_en,
	input wire logic [4:0] rd_addr,
	output cct_pkg::cct_charge_t rd_data
);

	cct_pkg::cct_charge_t mem [0:31];
	cct_pkg::cct_charge_t rd_data_reg;

	always_ff @(posedge sys_clk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
		if (rd_en)
		begin
			rd_data_reg <= mem[rd_addr];
		end
	end

	assign rd_data = rd_data_reg;

endmodule

// ### hdl/cct_tracker.sv
// Behaviour
// - issue only when all completions fit
// - never request beyond maximum read size
// - unsampled size assumes 128 bytes
// - first completion ends at boundary or end
// - last completion ends at request end
// - middle completions are whole boundary multiples
// - boundary 0=64, 1=128; default 64
// - header charge equals touched boundary blocks
// - accounting correct without completion merging
// - count option bounds outstanding requests only
// - per-packet frees when request fully satisfied
// - per-boundary frees one block per crossing
// - fine option frees data per credit
// - limit is min of data, header quotients
// - counters clear; issue when both fit
// - per-boundary crossing frees header, block data
// - fine option frees data per 16 bytes
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "cct_defs.svh"

module cct_tracker #(
	parameter cct_pkg::cct_option_t OPTION = cct_pkg::CCT_FINE_DATA_CREDIT_OPTION,
	parameter int TOTAL_HDR = `CCT_TOTAL_HDR,
	parameter int TOTAL_DATA_BYTES = `CCT_TOTAL_DATA_BYTES,
	parameter bit SAMPLE_MRRS = 1'b1,
	parameter bit SAMPLE_RCB = 1'b1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Software register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Endpoint configuration status
	input wire logic [15:0] dev_ctrl,
	input wire logic [1:0] rcb_status,
	// Request issue toward the endpoint
	output cct_pkg::cct_req_t np_req,
	output logic np_req_valid,
	// Completion arrival from the endpoint
	input wire logic cpl_valid,
	input wire cct_pkg::cct_cpl_t cpl
);

	// ==========================================================
	// Reserved space in credits
	localparam logic [7:0] HDR_CREDITS = 8'(TOTAL_HDR);
	localparam logic [10:0] DATA_CREDITS = 11'(TOTAL_DATA_BYTES >> `CCT_CREDIT_SHIFT);

	// ==========================================================
	// Helpers
	// Blocks of 2**shift bytes touched by a range; also the number of completions
	// or boundary crossings, since completions only split on those boundaries.
	function automatic logic [9:0] cct_blocks(input logic [11:0] addr, input logic [12:0] len,
		input logic [3:0] shift);
		logic [13:0] mask;
		logic [13:0] sum;
		mask = (14'h0001 << shift) - 14'h0001;
		sum = ({2'h0, addr} & mask) + {1'h0, len} + mask;
		cct_blocks = 10'(sum >> shift);
	endfunction

	function automatic logic [3:0] cct_rcb_shift(input logic [1:0] status, input logic func);
		logic bit_sel;
		bit_sel = SAMPLE_RCB ? status[func] : `CCT_DEFAULT_RCB;
		cct_rcb_shift = `CCT_RCB_BASE_SHIFT + {3'h0, bit_sel};
	endfunction

	// ==========================================================
	// State
	cct_pkg::cct_state_t state_reg, state_next;
	cct_pkg::cct_req_t held_reg, held_next;
	cct_pkg::cct_req_t out_req_reg, out_req_next;
	cct_pkg::cct_charge_t mem_rdata;
	logic out_valid_reg, out_valid_next;
	logic [31:0] addr_reg, addr_next;
	logic [7:0] hdr_reg, hdr_next;
	logic [10:0] data_reg, data_next;
	logic [7:0] count_reg, count_next;
	logic ovs_reg, ovs_next;
	logic lost_reg, lost_next;
	logic stall_reg, stall_next;
	logic pkt_free_reg, pkt_free_next;
	logic [31:0] rdata_reg, rdata_next;

	// ==========================================================
	// Request sizing
	logic [2:0] mrrs_code;
	logic [3:0] mrs_shift;
	logic [3:0] req_rcb_shift;
	logic [7:0] hdr_charge;
	logic [10:0] data_charge;
	logic [7:0] limit;
	logic [7:0] data_limit;
	logic [7:0] hdr_limit;
	logic oversize;
	logic fits;
	logic fire;

	always_comb
	begin
		mrrs_code = SAMPLE_MRRS ? dev_ctrl[`CCT_DEV_CTRL_MRRS] : `CCT_DEFAULT_MRRS;
		// Reserved codes fall back to the smallest size, which is always safe.
		if (mrrs_code > `CCT_MRRS_MAX_CODE)
		begin
			mrrs_code = `CCT_DEFAULT_MRRS;
		end
		mrs_shift = `CCT_MRRS_BASE_SHIFT + {1'h0, mrrs_code};
		req_rcb_shift = cct_rcb_shift(rcb_status, held_reg.func);
		hdr_charge = 8'(cct_blocks(held_reg.addr[`CCT_ADDR_LOW], held_reg.len, req_rcb_shift));
		if (OPTION == cct_pkg::CCT_PER_BOUNDARY_CREDIT_OPTION)
		begin
			data_charge = 11'({3'h0, hdr_charge} << (req_rcb_shift - `CCT_CREDIT_SHIFT));
		end
		else if (held_reg.no_data)
		begin
			data_charge = 11'h000;
		end
		else
		begin
			data_charge = 11'(cct_blocks(held_reg.addr[`CCT_ADDR_LOW], held_reg.len, `CCT_CREDIT_SHIFT));
		end
		// Limit assumes the smallest boundary of both functions' worst case is not needed:
		// the boundary of function 0 is taken, as request-count mode has no per-request state.
		data_limit = 8'(TOTAL_DATA_BYTES >> mrs_shift);
		hdr_limit = 8'(TOTAL_HDR >> (mrs_shift - cct_rcb_shift(rcb_status, 1'b0)));
		limit = (data_limit < hdr_limit) ? data_limit : hdr_limit;
		oversize = (held_reg.len == 13'h0000) || (held_reg.len > (13'h0001 << mrs_shift));
		if (OPTION == cct_pkg::CCT_REQUEST_COUNT_OPTION)
		begin
			fits = count_reg < limit;
		end
		else
		begin
			fits = ({1'h0, hdr_reg} + {1'h0, hdr_charge} <= {1'h0, HDR_CREDITS})
				&& ({1'h0, data_reg} + {1'h0, data_charge} <= {1'h0, DATA_CREDITS});
		end
		fire = (state_reg == cct_pkg::CCT_HOLD) && !oversize && fits;
	end

	// ==========================================================
	// Completion release
	logic [3:0] cpl_rcb_shift;
	logic [9:0] cpl_blocks;
	logic [7:0] free_hdr;
	logic [10:0] free_data;
	logic free_req;

	always_comb
	begin
		cpl_rcb_shift = cct_rcb_shift(rcb_status, cpl.func);
		// Per-boundary and fine frees follow actual completion lengths, so merged completions just free more at once.
		cpl_blocks = cct_blocks({5'h00, cpl.lower_addr}, cpl.len, cpl_rcb_shift);
		free_hdr = 8'h00;
		free_data = 11'h000;
		free_req = 1'b0;
		case (OPTION)
			cct_pkg::CCT_REQUEST_COUNT_OPTION:
			begin
				free_req = cpl_valid && cpl.last;
			end
			cct_pkg::CCT_PER_PACKET_CREDIT_OPTION:
			begin
				if (pkt_free_reg)
				begin
					free_hdr = mem_rdata.hdr;
					free_data = mem_rdata.data;
				end
			end
			cct_pkg::CCT_PER_BOUNDARY_CREDIT_OPTION:
			begin
				if (cpl_valid)
				begin
					free_hdr = 8'(cpl_blocks);
					free_data = 11'({1'h0, cpl_blocks} << (cpl_rcb_shift - `CCT_CREDIT_SHIFT));
				end
			end
			default:
			begin
				if (cpl_valid)
				begin
					free_hdr = 8'(cpl_blocks);
					free_data = 11'({1'h0, cct_blocks({5'h00, cpl.lower_addr}, cpl.len, `CCT_CREDIT_SHIFT)});
				end
			end
		endcase
	end

	// Per-packet charges wait here by tag until the request is fully satisfied.
	cct_charge_mem u_mem (
		.sys_clk(sys_clk),
		.wr_en(fire),
		.wr_addr(held_reg.tag),
		.wr_data({hdr_charge, data_charge}),
		.rd_en(cpl_valid && cpl.last),
		.rd_addr(cpl.tag),
		.rd_data(mem_rdata)
	);

	// ==========================================================
	// Next state
	always_comb
	begin
		state_next = state_reg;
		held_next = held_reg;
		addr_next = addr_reg;
		out_valid_next = fire;
		out_req_next = fire ? held_reg : out_req_reg;
		ovs_next = ovs_reg;
		lost_next = lost_reg;
		stall_next = 1'b0;
		pkt_free_next = cpl_valid && cpl.last;
		// Counters saturate at zero so a stray completion cannot wrap them.
		hdr_next = (free_hdr > hdr_reg) ? 8'h00 : hdr_reg - free_hdr;
		data_next = (free_data > data_reg) ? 11'h000 : data_reg - free_data;
		count_next = (free_req && count_reg != 8'h00) ? count_reg - 8'h01 : count_reg;
		if (fire)
		begin
			hdr_next = hdr_next + hdr_charge;
			data_next = data_next + data_charge;
			count_next = count_next + 8'h01;
		end
		if (reg_wr && reg_addr == `CCT_ADDR_STATUS)
		begin
			ovs_next = ovs_reg && !reg_wdata[`CCT_ST_OVERSIZE];
			lost_next = lost_reg && !reg_wdata[`CCT_ST_LOST];
		end
		case (state_reg)
			cct_pkg::CCT_IDLE:
			begin
				if (reg_wr && reg_addr == `CCT_ADDR_REQ)
				begin
					addr_next = reg_wdata;
				end
				else if (reg_wr && reg_addr == `CCT_ADDR_CMD)
				begin
					held_next.addr = addr_reg;
					held_next.len = reg_wdata[`CCT_CMD_LEN];
					held_next.tag = reg_wdata[`CCT_CMD_TAG];
					held_next.no_data = reg_wdata[`CCT_CMD_NODATA];
					held_next.func = reg_wdata[`CCT_CMD_FUNC];
					state_next = cct_pkg::CCT_HOLD;
				end
			end
			default:
			begin
				// Only one request is held; a command in this state is dropped and flagged.
				if (reg_wr && reg_addr == `CCT_ADDR_CMD)
				begin
					lost_next = 1'b1;
				end
				if (oversize)
				begin
					ovs_next = 1'b1;
					state_next = cct_pkg::CCT_IDLE;
				end
				else if (fire)
				begin
					state_next = cct_pkg::CCT_IDLE;
				end
				else
				begin
					stall_next = 1'b1;
				end
			end
		endcase
		rdata_next = 32'h0000_0000;
		if (reg_rd)
		begin
			if (reg_addr == `CCT_ADDR_REQ)
			begin
				rdata_next = addr_reg;
			end
			else if (reg_addr == `CCT_ADDR_PEND)
			begin
				rdata_next[`CCT_PEND_HDR] = hdr_reg;
				rdata_next[`CCT_PEND_DATA] = data_reg;
			end
			else if (reg_addr == `CCT_ADDR_STATUS)
			begin
				rdata_next[`CCT_ST_PEND] = state_reg == cct_pkg::CCT_HOLD;
				rdata_next[`CCT_ST_OVERSIZE] = ovs_reg;
				rdata_next[`CCT_ST_LOST] = lost_reg;
				rdata_next[`CCT_ST_STALL] = stall_reg;
				rdata_next[`CCT_ST_MRRS] = mrrs_code;
			end
			else if (reg_addr == `CCT_ADDR_LIMIT)
			begin
				rdata_next[`CCT_LIM_LIMIT] = limit;
				rdata_next[`CCT_LIM_COUNT] = count_reg;
			end
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			state_reg <= cct_pkg::CCT_IDLE;
			held_reg <= '0;
			out_req_reg <= '0;
			out_valid_reg <= 1'b0;
			addr_reg <= 32'h0000_0000;
			hdr_reg <= 8'h00;
			data_reg <= 11'h000;
			count_reg <= 8'h00;
			ovs_reg <= 1'b0;
			lost_reg <= 1'b0;
			stall_reg <= 1'b0;
			pkt_free_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			state_reg <= state_next;
			held_reg <= held_next;
			out_req_reg <= out_req_next;
			out_valid_reg <= out_valid_next;
			addr_reg <= addr_next;
			hdr_reg <= hdr_next;
			data_reg <= data_next;
			count_reg <= count_next;
			ovs_reg <= ovs_next;
			lost_reg <= lost_next;
			stall_reg <= stall_next;
			pkt_free_reg <= pkt_free_next;
			rdata_reg <= rdata_next;
		end
	end

	assign np_req = out_req_reg;
	assign np_req_valid = out_valid_reg;
	assign reg_rdata = rdata_reg;

	// ==========================================================
	// Checks
	chk_hdr_bound: assert property (@(posedge sys_clk) disable iff (!rst_n) hdr_reg <= HDR_CREDITS)
		else $error("pending header credits exceed reserve");
	chk_data_bound: assert property (@(posedge sys_clk) disable iff (!rst_n) data_reg <= DATA_CREDITS)
		else $error("pending data credits exceed reserve");
	chk_req_size: assert property (@(posedge sys_clk) disable iff (!rst_n)
		fire |-> held_reg.len <= (13'h0001 << mrs_shift) ##1 np_req_valid && np_req.len == $past(held_reg.len))
		else $error("request issued beyond maximum read size");
	chk_count_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(OPTION == cct_pkg::CCT_REQUEST_COUNT_OPTION && fire) |-> count_reg < limit)
		else $error("outstanding request limit overrun");
	chk_alloc_add: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(fire && free_hdr == 8'h00) |=> hdr_reg == $past(hdr_reg) + $past(hdr_charge))
		else $error("header credits not charged on issue");
	chk_mrrs_default: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!SAMPLE_MRRS |-> mrs_shift == `CCT_MRRS_BASE_SHIFT)
		else $error("unsampled size is not 128 bytes");
	chk_rcb_default: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!SAMPLE_RCB |-> cpl_rcb_shift == `CCT_RCB_BASE_SHIFT)
		else $error("unsampled boundary is not 64 bytes");
	chk_reset_clear: assert property (@(posedge sys_clk)
		$rose(rst_n) |-> hdr_reg == 8'h00 && data_reg == 11'h000 && !np_req_valid)
		else $error("counters not cleared by reset");
	chk_boundary_free: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(OPTION == cct_pkg::CCT_PER_BOUNDARY_CREDIT_OPTION && cpl_valid && !fire && hdr_reg >= free_hdr)
		|=> hdr_reg == $past(hdr_reg) - $past(free_hdr))
		else $error("boundary crossings not released");
	cov_issue: cover property (@(posedge sys_clk) disable iff (!rst_n) np_req_valid);
	cov_stall: cover property (@(posedge sys_clk) disable iff (!rst_n) stall_reg ##1 fire);
	cov_oversize: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(ovs_reg));
	cov_release: cover property (@(posedge sys_clk) disable iff (!rst_n) free_hdr != 8'h00 && fire);

endmodule

// ### verif/cct_endpoint_model.sv
`timescale 1ns/1ps

// ==========================================================
// Endpoint side: configuration status and worst-case completions
module cct_endpoint_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Settings chosen by the bench
	input wire logic [2:0] size_code,
	input wire logic [1:0] rcb_bits,
	input wire logic hold_off,
	// Requests from the tracker
	input wire cct_pkg::cct_req_t np_req,
	input wire logic np_req_valid,
	// Toward the tracker
	output logic [15:0] dev_ctrl,
	output logic [1:0] rcb_status,
	output logic cpl_valid,
	output cct_pkg::cct_cpl_t cpl,
	output logic overflow
);
	cct_pkg::cct_req_t pend_q[$];
	logic [31:0] cur;
	logic [31:0] stop;
	bit started;
	int hdr_out;
	int blk;
	int step;

	// The low twelve control bits carry a busy pattern and bit 15 is zero, so only the size field may matter.
	assign dev_ctrl = {1'h0, size_code, 12'hA5A};
	assign rcb_status = rcb_bits;

	// Every block is answered by its own completion, the most headers a host may use.
	always @(posedge sys_clk)
	begin
		cpl_valid <= 1'b0;
		if (!rst_n)
		begin
			pend_q.delete();
			hdr_out = 0;
			started = 0;
			overflow <= 1'b0;
		end
		else
		begin
			if (np_req_valid)
			begin
				blk = 64 << rcb_bits[np_req.func];
				hdr_out += (np_req.addr % blk + np_req.len + blk - 1) / blk;
				pend_q.push_back(np_req);
			end
			if (hdr_out > 64)
				overflow <= 1'b1;
			if (!hold_off && pend_q.size() > 0)
			begin
				if (!started)
				begin
					cur = pend_q[0].addr;
					started = 1;
				end
				stop = pend_q[0].addr + pend_q[0].len;
				blk = 64 << rcb_bits[pend_q[0].func];
				step = blk - cur % blk;
				if (cur + step > stop)
					step = stop - cur;
				cpl_valid <= 1'b1;
				cpl <= {cur[6:0], 13'(step), pend_q[0].tag, pend_q[0].func, 1'(cur + step == stop)};
				cur += step;
				hdr_out -= 1;
				if (cur == stop)
				begin
					void'(pend_q.pop_front());
					started = 0;
				end
			end
			else
			begin
				// An idle header shows the inverse of its last value, so stale fields cannot pass.
				cpl <= ~cpl;
			end
		end
	end
endmodule

// ### verif/cct_tracker_test.sv
`timescale 1ns/1ps
`include "cct_defs.svh"

module cct_tracker_test;
	logic sys_clk;
	logic rst_n;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic [15:0] dev_ctrl;
	logic [1:0] rcb_status;
	cct_pkg::cct_req_t np_req;
	logic np_req_valid;
	logic cpl_valid;
	cct_pkg::cct_cpl_t cpl;
	logic [2:0] size_code;
	logic [1:0] rcb_bits;
	logic hold_off;
	logic overflow;
	logic [31:0] rd;
	int fail_count;
	int checks_done;

	cct_tracker u_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dev_ctrl(dev_ctrl),
		.rcb_status(rcb_status), .np_req(np_req), .np_req_valid(np_req_valid),
		.cpl_valid(cpl_valid), .cpl(cpl)
	);

	cct_endpoint_model u_ep (
		.sys_clk(sys_clk), .rst_n(rst_n), .size_code(size_code), .rcb_bits(rcb_bits),
		.hold_off(hold_off), .np_req(np_req), .np_req_valid(np_req_valid), .dev_ctrl(dev_ctrl),
		.rcb_status(rcb_status), .cpl_valid(cpl_valid), .cpl(cpl), .overflow(overflow)
	);

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		rd = reg_rdata;
	endtask

	task automatic pend(input int h, input int d);
		reg_read(`CCT_ADDR_PEND);
		check(rd, 32'(d) << 16 | 32'(h));
	endtask

	task automatic wait_issue(input logic [31:0] a, input logic [12:0] n, input logic [4:0] t,
		input logic f, input bit ok);
		bit seen;
		seen = 0;
		for (int i = 0; i < 8 && !seen; i++)
		begin
			@(negedge sys_clk);
			if (np_req_valid === 1'b1)
			begin
				seen = 1;
				check(np_req.addr, a);
				check({np_req.len, np_req.tag, np_req.func, np_req.no_data}, {n, t, f, 1'b0});
			end
		end
		check(32'(seen), 32'(ok));
	endtask

	task automatic send(input logic [31:0] a, input logic [12:0] n, input logic [4:0] t,
		input logic f, input bit ok);
		reg_write(`CCT_ADDR_REQ, a);
		reg_write(`CCT_ADDR_CMD, {6'h0, f, 1'b0, 3'h0, t, 3'h0, n});
		wait_issue(a, n, t, f, ok);
	endtask

	// Completions are released here and in s_stall, so charges can be read while held.
	task automatic drain;
		hold_off <= 1'b0;
		for (int i = 0; i < 60; i++)
		begin
			reg_read(`CCT_ADDR_PEND);
			if (rd === 32'h0 && u_ep.pend_q.size() == 0)
				break;
		end
		hold_off <= 1'b1;
		check(rd, 32'h0);
	endtask

	task automatic end_of_test;
		$display("checks_done %0d fail_count %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic s_reset;
		pend(0, 0);
		reg_read(8'h14);
		check(rd, 32'h0);
	endtask

	task automatic s_charge;
		send(32'h0000_007C, 13'd8, 5'h01, 1'b0, 1'b1);
		pend(2, 2);
		send(32'h1234_5670, 13'd100, 5'h02, 1'b0, 1'b1);
		pend(5, 9);
		drain();
	endtask

	task automatic s_rcb;
		@(posedge sys_clk);
		rcb_bits <= 2'b10;
		send(32'h0000_0020, 13'd96, 5'h03, 1'b1, 1'b1);
		pend(1, 6);
		send(32'h0000_0020, 13'd96, 5'h04, 1'b0, 1'b1);
		pend(3, 12);
		drain();
		@(posedge sys_clk);
		rcb_bits <= 2'b00;
	endtask

	task automatic s_size;
		int lim;
		for (int c = 0; c < 8; c++)
		begin
			@(posedge sys_clk);
			size_code <= 3'(c);
			lim = (c <= 5) ? (128 << c) : 128;
			send(32'h0, 13'(lim), 5'(c), 1'b0, 1'b1);
			pend(lim / 64, lim / 16);
			drain();
			send(32'h0, 13'(lim + 1), 5'(c), 1'b0, 1'b0);
			reg_read(`CCT_ADDR_STATUS);
			check(rd[3:0], 4'h2);
			reg_write(`CCT_ADDR_STATUS, 32'h2);
		end
		send(32'h0, 13'd0, 5'h09, 1'b0, 1'b0);
		reg_write(`CCT_ADDR_STATUS, 32'h2);
	endtask

	task automatic s_stall;
		@(posedge sys_clk);
		size_code <= 3'h5;
		send(32'h0, 13'd4096, 5'h0A, 1'b0, 1'b1);
		pend(64, 256);
		send(32'h0000_0100, 13'd4, 5'h0B, 1'b0, 1'b0);
		reg_write(`CCT_ADDR_CMD, 32'h0000_0004);
		reg_read(`CCT_ADDR_STATUS);
		check(rd[3:0], 4'hD);
		hold_off <= 1'b0;
		wait_issue(32'h0000_0100, 13'd4, 5'h0B, 1'b0, 1'b1);
		drain();
		check(32'(overflow), 32'h0);
	endtask

	// ==========================================================
	// Clock, reset and main sequence
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	initial
	begin
		fail_count = 0;
		checks_done = 0;
		rst_n = 1'b0;
		reg_addr = 8'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		size_code = 3'h0;
		rcb_bits = 2'b00;
		hold_off = 1'b1;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		s_reset();
		s_charge();
		s_rcb();
		s_size();
		s_stall();
		end_of_test();
	end
endmodule
